// >>> hw/ccc_cfg.svh
// Offsets, field positions and time points of the channel command logic.
// Assumes 36-bit storage words, position 0 is the sign bit (index 35).
`ifndef CCC_CFG_SVH
`define CCC_CFG_SVH

// Time points of one channel cycle, 0 through 10
`define CCC_TP_LAST     4'ha
`define CCC_TP_LOAD     4'h7
`define CCC_TP_ZTEST    4'h1
`define CCC_TP_INCR     4'h1
`define CCC_TP_CTR_CLR  4'h2
`define CCC_TP_LCC_LD   4'h1
`define CCC_TP_SMS_CLR  4'h3
`define CCC_TP_SMS_END  4'h8
`define CCC_TP_ICC_CLR  4'h0
`define CCC_TP_ICC_LD   4'h5
`define CCC_TP_XFER     4'h5

// Command word fields (index = 35 - position)
`define CCC_OP_HI       35
`define CCC_OP_LO       33
`define CCC_CNT_HI      32
`define CCC_CNT_LO      30
`define CCC_IND_BIT     15
`define CCC_AC_HI       17
`define CCC_AC_LO       0

// Operation codes
`define CCC_OP_SMS      3'h1
`define CCC_OP_LCC      3'h2
`define CCC_OP_ICC      3'h3
`define CCC_OP_TDC      3'h4

// Insert counts with special meaning
`define CCC_CNT_STATUS  3'h0
`define CCC_CNT_NOP     3'h7
`define CCC_CHAR_LAST   3'h6

`endif

// >>> hw/ccc_pkg.sv
// Types shared by the channel command logic.
// Assumes ccc_cfg.svh for all numeric constants.
package ccc_pkg;

    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_WAIT_FETCH = 6'h0_001,
        ST_FETCH      = 6'h0_002,
        ST_WAIT_WORD  = 6'h0_004,
        ST_WORD       = 6'h0_008,
        ST_INCR       = 6'h0_010,
        ST_EXEC       = 6'h0_020
    } ccc_state_t;

    // Command as held in operation register, word counter, address counter
    typedef struct packed {
        logic [2:0]  op;
        logic [2:0]  cnt;
        logic        ind;
        logic [17:0] ac;
    } ccc_cmd_t;

    // Mode status triggers, positions 29 through 35
    typedef struct packed {
        logic noncon_int_en;
        logic read_backward;
        logic bcd_mode;
        logic inh_unusual_end;
        logic inh_attn1;
        logic inh_attn2;
        logic sel_unit2;
    } ccc_stat_t;

endpackage

// >>> hw/ccc_time_ring.sv
// Time point counter of a channel cycle, 0 through 10.
// Assumes run_i stays high for every cycle the channel owns.
`timescale 1ns/1ps
`include "ccc_cfg.svh"
module ccc_time_ring (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // Control
    input  wire logic       run_i,
    // Time point
    output logic [3:0]      tp_o,
    output logic            last_o
);
    logic [3:0] tp_q;
    logic [3:0] tp_d;

    // Held at 0 while waiting, so a granted cycle starts at time 0
    always_comb begin
        if (!run_i || tp_q == `CCC_TP_LAST) begin
            tp_d = 4'h0;
        end else begin
            tp_d = tp_q + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tp_q <= 4'h0;
        end else begin
            tp_q <= tp_d;
        end
    end

    assign tp_o   = tp_q;
    assign last_o = run_i && (tp_q == `CCC_TP_LAST);
endmodule

// >>> hw/ccc_asm_reg.sv
// Assembly register: six 6-bit characters, character 1 in the high bits.
// Assumes clear and load strobes come from different time points.
`timescale 1ns/1ps
`include "ccc_cfg.svh"
module ccc_asm_reg (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // Character-in switch
    input  wire logic        clr_i,
    input  wire logic        ld_i,
    input  wire logic [2:0]  sel_i,
    input  wire logic [5:0]  char_i,
    // Contents
    output logic [35:0]      asm_o
);
    logic [35:0] asm_q;
    logic [35:0] asm_d;

    // A select outside 1..6 reaches no character, so nothing changes
    always_comb begin
        asm_d = asm_q;
        for (int i = 1; i <= 6; i++) begin
            if (sel_i == 3'(i)) begin
                if (clr_i) begin
                    asm_d[36 - 6*i +: 6] = 6'h00;
                end else if (ld_i) begin
                    asm_d[36 - 6*i +: 6] = asm_q[36 - 6*i +: 6] | char_i;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            asm_q <= 36'h0_0000_0000;
        end else begin
            asm_q <= asm_d;
        end
    end

    assign asm_o = asm_q;
endmodule

// >>> hw/ccc_cmd_exec.sv
// Command execution for set-mode, load/insert loop counter, branch-decrement.
// Assumes host core storage grants fetch and word cycles on this clock.
//
// What this block does
// - Each set-mode bit sets or clears trigger
// - Machine and power-on reset clear triggers
// - Indirect set-mode takes bits from pointed word
// - Bits 33/34 mask attentions, 35 selects unit
// - Bits 29-32 drive interrupt, backward, BCD, unusual
// - Load command at time 7; decode next 0
// - Set-mode execute clears, loads mask 29-35
// - Clear at time 3, reload until 8
// - Load loop counter from positions 30-35
// - Clear loop counter in increment cycle
// - Execute loads counter, requests next fetch
// - Indirect load takes six low bits
// - Insert count 1-6 writes counter character
// - Count zero writes status to character 6
// - Count seven changes nothing
// - Clear character at 0, load at 5
// - Increment command counter, test counter zero
// - Nonzero counter: decrement and branch
// - Zero counter: unchanged, next sequential command
// - Step pulse spans execute; counts on rise
// - Taken branch sets gate, clears counter
// - Gate makes address counter drive fetch address
// - Taken branch copies address into command counter
// - Counter-zero cleared each fetch; retestable
`timescale 1ns/1ps
`include "ccc_cfg.svh"
module ccc_cmd_exec (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        machine_reset_i,
    // Host storage cycles
    output logic             fetch_req_o,
    output logic             word_req_o,
    input  wire logic        cycle_grant_i,
    output logic [14:0]      mem_addr_o,
    input  wire logic [35:0] store_bus_i,
    // Attention pins from the units
    input  wire logic        attn1_i,
    input  wire logic        attn2_i,
    output logic             attn1_o,
    output logic             attn2_o,
    // Mode status
    output ccc_pkg::ccc_stat_t status_o,
    // Counters and state
    output logic [14:0]      cmd_ctr_o,
    output logic [5:0]       loop_ctr_o,
    output logic             ctr_zero_o,
    output logic             xfer_gate_o,
    output logic             step_o,
    output logic             op_active_o,
    output logic [35:0]      asm_reg_o
);
    ccc_pkg::ccc_state_t state_q;
    ccc_pkg::ccc_state_t state_d;
    ccc_pkg::ccc_cmd_t   cmd_q;
    ccc_pkg::ccc_cmd_t   cmd_d;
    ccc_pkg::ccc_stat_t  stat_q;
    ccc_pkg::ccc_stat_t  stat_d;
    logic [14:0]         cc_q;
    logic [14:0]         cc_d;
    logic [14:0]         addr_q;
    logic [14:0]         addr_d;
    logic [5:0]          lctr_q;
    logic [5:0]          lctr_d;
    logic                zero_q;
    logic                zero_d;
    logic                xgate_q;
    logic                xgate_d;
    logic                step_q;
    logic                step_d;
    logic                opact_q;
    logic                opact_d;
    logic [1:0]          attn_s1_q;
    logic [1:0]          attn_s2_q;
    logic [3:0]          tp;
    logic                last;
    logic                run;
    logic                in_exec;
    logic                in_incr;
    logic                is_sms;
    logic                is_lcc;
    logic                is_icc;
    logic                is_tdc;
    logic                taken;

    // True when the decoded operation matches
    function automatic logic op_is(input logic [2:0] op, input logic [2:0] code);
        op_is = (op == code);
    endfunction

    // Cycle timing
    assign run = (state_q == ccc_pkg::ST_FETCH) || (state_q == ccc_pkg::ST_WORD)
              || (state_q == ccc_pkg::ST_INCR)  || (state_q == ccc_pkg::ST_EXEC);

    ccc_time_ring u_time (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .run_i   (run),
        .tp_o    (tp),
        .last_o  (last)
    );

    // Decode is gated by op_active so a half-loaded command does nothing
    assign in_exec = (state_q == ccc_pkg::ST_EXEC);
    assign in_incr = (state_q == ccc_pkg::ST_INCR);
    assign is_sms  = opact_q && op_is(cmd_q.op, `CCC_OP_SMS);
    assign is_lcc  = opact_q && op_is(cmd_q.op, `CCC_OP_LCC);
    assign is_icc  = opact_q && op_is(cmd_q.op, `CCC_OP_ICC);
    assign is_tdc  = opact_q && op_is(cmd_q.op, `CCC_OP_TDC);
    assign taken   = is_tdc && !zero_q;

    // Sequencer: fetch, optional indirect word, increment, execute
    always_comb begin
        state_d = state_q;
        cmd_d   = cmd_q;
        cc_d    = cc_q;
        addr_d  = addr_q;
        zero_d  = zero_q;
        xgate_d = xgate_q;
        opact_d = opact_q;
        case (state_q)
            ccc_pkg::ST_WAIT_FETCH: begin
                if (cycle_grant_i) begin
                    state_d = ccc_pkg::ST_FETCH;
                    opact_d = 1'b0;
                    zero_d  = 1'b0;
                    if (xgate_q) begin
                        addr_d = cmd_q.ac[14:0];
                        cc_d   = cc_q | cmd_q.ac[14:0];
                    end else begin
                        addr_d = cc_q;
                    end
                end
            end
            ccc_pkg::ST_FETCH: begin
                if (tp == `CCC_TP_LOAD) begin
                    cmd_d.op  = store_bus_i[`CCC_OP_HI:`CCC_OP_LO];
                    cmd_d.cnt = store_bus_i[`CCC_CNT_HI:`CCC_CNT_LO];
                    cmd_d.ind = store_bus_i[`CCC_IND_BIT];
                    cmd_d.ac  = store_bus_i[`CCC_AC_HI:`CCC_AC_LO];
                end
                if (last) begin
                    xgate_d = 1'b0;
                    opact_d = 1'b1;
                    state_d = cmd_q.ind ? ccc_pkg::ST_WAIT_WORD : ccc_pkg::ST_INCR;
                end
            end
            ccc_pkg::ST_WAIT_WORD: begin
                if (cycle_grant_i) begin
                    state_d = ccc_pkg::ST_WORD;
                    addr_d  = cmd_q.ac[14:0];
                end
            end
            ccc_pkg::ST_WORD: begin
                // Pointed word replaces the address counter: mask or count
                if (tp == `CCC_TP_LOAD) begin
                    cmd_d.ac = store_bus_i[`CCC_AC_HI:`CCC_AC_LO];
                end
                if (last) begin
                    state_d = ccc_pkg::ST_INCR;
                end
            end
            ccc_pkg::ST_INCR: begin
                if (tp == `CCC_TP_INCR) begin
                    cc_d = cc_q + 15'h0_001;
                end
                if (is_tdc && tp == `CCC_TP_ZTEST && lctr_q == 6'h00) begin
                    zero_d = 1'b1;
                end
                if (last) begin
                    state_d = ccc_pkg::ST_EXEC;
                end
            end
            ccc_pkg::ST_EXEC: begin
                if (taken && tp == `CCC_TP_XFER) begin
                    xgate_d = 1'b1;
                    cc_d    = 15'h0_000;
                end
                if (last) begin
                    state_d = ccc_pkg::ST_WAIT_FETCH;
                end
            end
            default: begin
                state_d = ccc_pkg::ST_WAIT_FETCH;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= ccc_pkg::ST_WAIT_FETCH;
            cmd_q   <= '0;
            cc_q    <= 15'h0_000;
            addr_q  <= 15'h0_000;
            zero_q  <= 1'b0;
            xgate_q <= 1'b0;
            opact_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cmd_q   <= cmd_d;
            cc_q    <= cc_d;
            addr_q  <= addr_d;
            zero_q  <= zero_d;
            xgate_q <= xgate_d;
            opact_q <= opact_d;
        end
    end

    // Execution: mode status, loop counter and step pulse
    always_comb begin
        stat_d = stat_q;
        lctr_d = lctr_q;
        step_d = step_q;
        if (in_exec && is_sms) begin
            // Old value is ORed in early, so clear at 3 and reload
            if (tp < `CCC_TP_SMS_CLR) begin
                stat_d = stat_q | cmd_q.ac[6:0];
            end else if (tp == `CCC_TP_SMS_CLR) begin
                stat_d = '0;
            end else if (tp <= `CCC_TP_SMS_END) begin
                stat_d = cmd_q.ac[6:0];
            end
        end
        if (in_incr && is_lcc && tp == `CCC_TP_CTR_CLR) begin
            lctr_d = 6'h00;
        end
        if (in_exec && is_lcc && tp == `CCC_TP_LCC_LD) begin
            lctr_d = cmd_q.ac[5:0];
        end
        // Step rises as execute starts and the counter moves on the rise
        if (in_incr && last && taken) begin
            step_d = 1'b1;
            lctr_d = lctr_q - 6'h01;
        end else if (in_exec && last) begin
            step_d = 1'b0;
        end
        if (machine_reset_i) begin
            stat_d = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            stat_q <= '0;
            lctr_q <= 6'h00;
            step_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            lctr_q <= lctr_d;
            step_q <= step_d;
        end
    end

    // Insert: count zero aims at character 6, seven reaches nothing
    ccc_asm_reg u_asm (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .clr_i   (in_exec && is_icc && tp == `CCC_TP_ICC_CLR),
        .ld_i    (in_exec && is_icc && tp == `CCC_TP_ICC_LD),
        .sel_i   ((cmd_q.cnt == `CCC_CNT_STATUS) ? `CCC_CHAR_LAST : cmd_q.cnt),
        .char_i  ((cmd_q.cnt == `CCC_CNT_STATUS) ? stat_q[5:0] : lctr_q),
        .asm_o   (asm_reg_o)
    );

    // Attention pins cross in through two flops before masking
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            attn_s1_q <= 2'h0;
            attn_s2_q <= 2'h0;
        end else begin
            attn_s1_q <= {attn2_i, attn1_i};
            attn_s2_q <= attn_s1_q;
        end
    end

    // Outputs
    assign attn1_o     = attn_s2_q[0] && !stat_q.inh_attn1;
    assign attn2_o     = attn_s2_q[1] && !stat_q.inh_attn2;
    assign status_o    = stat_q;
    assign fetch_req_o = in_exec || (state_q == ccc_pkg::ST_WAIT_FETCH);
    assign word_req_o  = (state_q == ccc_pkg::ST_WAIT_WORD);
    assign mem_addr_o  = addr_q;
    assign cmd_ctr_o   = cc_q;
    assign loop_ctr_o  = lctr_q;
    assign ctr_zero_o  = zero_q;
    assign xfer_gate_o = xgate_q;
    assign step_o      = step_q;
    assign op_active_o = opact_q;

    // Checks
    sms_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
        in_exec && is_sms && tp == `CCC_TP_SMS_CLR |=> stat_q == '0)
        else $error("status not cleared at time 3");
    sms_load_a: assert property (@(posedge clk_i) disable iff (reset_i)
        in_exec && is_sms && tp == `CCC_TP_SMS_END && !machine_reset_i
        |=> stat_q == $past(cmd_q.ac[6:0]))
        else $error("status not loaded from mask");
    stat_reset_a: assert property (@(posedge clk_i) disable iff (reset_i)
        machine_reset_i |=> stat_q == '0)
        else $error("machine reset left status set");
    lcc_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
        in_incr && is_lcc && tp == `CCC_TP_CTR_CLR |=> lctr_q == 6'h00)
        else $error("loop counter not cleared");
    lcc_load_a: assert property (@(posedge clk_i) disable iff (reset_i)
        in_exec && is_lcc && tp == `CCC_TP_LCC_LD |=> lctr_q == $past(cmd_q.ac[5:0]))
        else $error("loop counter not loaded");
    tdc_step_a: assert property (@(posedge clk_i) disable iff (reset_i)
        in_incr && last && taken
        |=> step_q && lctr_q == $past(lctr_q) - 6'h01 ##10 step_q ##1 !step_q)
        else $error("step or decrement wrong");
    zero_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
        in_incr && last && is_tdc && zero_q |=> (lctr_q == 6'h00 && !step_q)[*8])
        else $error("zero counter changed");
    xfer_gate_a: assert property (@(posedge clk_i) disable iff (reset_i)
        in_exec && taken && tp == `CCC_TP_XFER |=> xgate_q && cc_q == 15'h0_000)
        else $error("taken branch did not gate");
    fetch_addr_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state_q == ccc_pkg::ST_WAIT_FETCH && cycle_grant_i && xgate_q
        |=> addr_q == $past(cmd_q.ac[14:0]) && cc_q == $past(cmd_q.ac[14:0]))
        else $error("branch target not used");
    fetch_load_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state_q == ccc_pkg::ST_FETCH && tp == `CCC_TP_LOAD
        |=> cmd_q.op == $past(store_bus_i[35:33]) ##[1:3] !opact_q ##[1:4] opact_q)
        else $error("command not loaded at time 7");
endmodule

// >>> dv/ccc_host_model.sv
// Host core storage and cycle priority model for the channel command logic.
// Assumes one grant pulse per storage cycle and a bus sampled late in the cycle.
`timescale 1ns/1ps
module ccc_host_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // Requests from the channel
    input  wire logic        fetch_req_i,
    input  wire logic        word_req_i,
    input  wire logic [14:0] mem_addr_i,
    // Answers to the channel
    output logic             grant_o,
    output logic [35:0]      bus_o
);
    logic [35:0] mem [0:32767];
    logic [35:0] idle_q;
    int          hi_cnt;
    int          busy;
    int          delay;

    // Fetch grants wait out the execute cycle, where the request also stands
    always @(posedge clk_i) begin
        if (reset_i) begin
            grant_o <= 1'b0;
            hi_cnt  <= 0;
            busy    <= 0;
            delay   <= 0;
            idle_q  <= 36'h5_a5a5_a5a5;
        end else begin
            idle_q <= ~idle_q;
            hi_cnt <= (fetch_req_i || word_req_i) ? hi_cnt + 1 : 0;
            if (busy > 0) begin
                grant_o <= 1'b0;
                busy    <= busy - 1;
            end else if (!grant_o && ((word_req_i && hi_cnt >= delay) ||
                         (fetch_req_i && hi_cnt >= 12 + delay))) begin
                grant_o <= 1'b1;
                busy    <= 11;
                delay   <= $urandom % 4; // Slow and prompt answers alike
            end else begin
                grant_o <= 1'b0;
            end
        end
    end

    // Outside a storage cycle the bus shows a changing pattern, never stale data
    assign bus_o = (busy != 0) ? mem[mem_addr_i] : idle_q;
endmodule

// >>> dv/tb_channel_control_counter_commands.sv
// Self-checking bench for the channel command logic with a behavioural model.
// Assumes the host model grants only when the channel waits for a cycle.
`timescale 1ns/1ps
module tb_channel_control_counter_commands;
    logic               clk_i;
    logic               reset_i;
    logic               machine_reset_i;
    logic               fetch_req_o;
    logic               word_req_o;
    logic               cycle_grant_i;
    logic [14:0]        mem_addr_o;
    logic [35:0]        store_bus_i;
    logic               attn1_i;
    logic               attn2_i;
    logic               attn1_o;
    logic               attn2_o;
    ccc_pkg::ccc_stat_t status_o;
    logic [14:0]        cmd_ctr_o;
    logic [5:0]         loop_ctr_o;
    logic               ctr_zero_o;
    logic               xfer_gate_o;
    logic               step_o;
    logic               op_active_o;
    logic [35:0]        asm_reg_o;
    int                 failures;
    int                 samples_checked;
    int                 pc;
    int                 loop_m;
    int                 taken_m;
    int                 zero_m;
    logic [6:0]         stat_m;
    logic [35:0]        asm_m;
    logic               a1_m;
    logic               a2_m;
    logic               mr;
    logic [35:0]        w;
    logic [2:0]         op;

    ccc_cmd_exec dut_u (
        .clk_i(clk_i), .reset_i(reset_i), .machine_reset_i(machine_reset_i),
        .fetch_req_o(fetch_req_o), .word_req_o(word_req_o),
        .cycle_grant_i(cycle_grant_i), .mem_addr_o(mem_addr_o),
        .store_bus_i(store_bus_i), .attn1_i(attn1_i), .attn2_i(attn2_i),
        .attn1_o(attn1_o), .attn2_o(attn2_o), .status_o(status_o),
        .cmd_ctr_o(cmd_ctr_o), .loop_ctr_o(loop_ctr_o), .ctr_zero_o(ctr_zero_o),
        .xfer_gate_o(xfer_gate_o), .step_o(step_o), .op_active_o(op_active_o),
        .asm_reg_o(asm_reg_o)
    );

    ccc_host_model host_u (
        .clk_i(clk_i), .reset_i(reset_i), .fetch_req_i(fetch_req_o),
        .word_req_i(word_req_o), .mem_addr_i(mem_addr_o),
        .grant_o(cycle_grant_i), .bus_o(store_bus_i)
    );

    // Clock at 200 MHz
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Value comparison with a count of every sample
    task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    function automatic logic [35:0] mk(input logic [2:0] o, input logic [2:0] c,
                                       input logic [17:0] a);
        return {o, c, 12'h000, a};
    endfunction

    // Bounded wait for the cycle in which a fetch grant is high
    task automatic wait_fetch();
        for (int i = 0; i < 300; i++) begin
            @(negedge clk_i);
            if (cycle_grant_i === 1'b1 && fetch_req_o === 1'b1) return;
        end
        failures++;
        $display("MISMATCH fetch_grant expected 1 seen 0");
        finish_test();
    endtask

    // Reference behaviour of one command, applied once it has been fetched
    task automatic model_step();
        logic [17:0] ac;
        int          pos;
        w  = host_u.mem[pc];
        op = w[35:33];
        ac = w[17:0];
        if (w[15]) ac = host_u.mem[ac[14:0]][17:0];
        taken_m = 0;
        zero_m  = 0;
        pc      = (pc + 1) % 32768;
        case (op)
            3'h1: stat_m = ac[6:0];
            3'h2: loop_m = ac[5:0];
            3'h3: if (w[32:30] != 3'h7) begin
                pos = (w[32:30] == 3'h0) ? 6 : w[32:30];
                asm_m[(6 - pos) * 6 +: 6] = (w[32:30] == 3'h0) ? stat_m[5:0] : 6'(loop_m);
            end
            3'h4: if (loop_m != 0) begin
                loop_m--;
                pc      = ac[14:0];
                taken_m = 1;
            end else begin
                zero_m = 1;
            end
            default: ;
        endcase
    endtask

    // Main sequence: a fixed prelude for the awkward cases, then random commands
    initial begin
        reset_i         = 1'b1;
        machine_reset_i = 1'b0;
        attn1_i         = 1'b0;
        attn2_i         = 1'b0;
        failures        = 0;
        samples_checked = 0;
        void'($urandom(32'h0225));
        host_u.mem[0] = mk(3'h2, 3'h0, 18'h0_0001);
        host_u.mem[1] = mk(3'h4, 3'h0, 18'h0_0001); // Taken once, then falls through
        host_u.mem[2] = mk(3'h4, 3'h0, 18'h0_0001); // Zero counter tested again
        host_u.mem[3] = mk(3'h1, 3'h0, 18'h0_005a);
        host_u.mem[4] = mk(3'h2, 3'h0, 18'h0_002d);
        for (int i = 0; i < 8; i++) host_u.mem[5 + i] = mk(3'h3, 3'((i + 7) % 8), 18'h0_0000);
        for (int i = 13; i < 32768; i++) begin
            op = 3'(1 + $urandom % 5); // Code 5 decodes as a no-op
            w  = {op, 3'($urandom), 12'($urandom), 18'($urandom)};
            if (op == 3'h2) w[5:0] = 6'($urandom % 4); // Small counts reach zero often
            w[15] = (op != 3'h4) && ($urandom % 4 == 0);
            host_u.mem[i] = w;
        end
        pc      = 0;
        loop_m  = 0;
        taken_m = 0;
        zero_m  = 0;
        stat_m = '0;
        asm_m  = '0;
        a1_m   = 1'b0;
        a2_m   = 1'b0;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        for (int k = 0; k < 200; k++) begin
            wait_fetch();
            chk("status", status_o, stat_m);
            chk("loop_ctr", loop_ctr_o, loop_m);
            chk("asm_reg", asm_reg_o, asm_m);
            chk("cmd_ctr", cmd_ctr_o, taken_m ? 0 : pc);
            chk("xfer_gate", xfer_gate_o, taken_m);
            chk("ctr_zero", ctr_zero_o, zero_m);
            chk("attn1", attn1_o, a1_m & ~stat_m[2]);
            chk("attn2", attn2_o, a2_m & ~stat_m[1]);
            chk("step", step_o, 1'b0);
            chk("op_active", op_active_o, k != 0);
            mr = (k % 7 == 3);
            @(posedge clk_i);
            machine_reset_i <= mr;
            a1_m = 1'($urandom);
            a2_m = 1'($urandom);
            attn1_i <= a1_m;
            attn2_i <= a2_m;
            @(posedge clk_i);
            machine_reset_i <= 1'b0;
            @(negedge clk_i);
            chk("mem_addr", mem_addr_o, pc);
            chk("op_active", op_active_o, 1'b0);
            chk("fetch_req", fetch_req_o, 1'b0);
            chk("word_req", word_req_o, 1'b0);
            if (mr) stat_m = '0;
            model_step();
        end
        finish_test();
    end
endmodule
